// ==== verilog/gpc_port_regs.vh ====
// register offsets, field positions, reset values and timing counts of the
// port control block; assumes an 8-bit register bus with byte addresses
`ifndef GPC_PORT_REGS_VH
`define GPC_PORT_REGS_VH

`define GPC_ADDR_P0_DATA 8'h80
`define GPC_ADDR_P1_DATA 8'h88
`define GPC_ADDR_P2_DATA 8'h90
`define GPC_ADDR_P0_OD 8'h91
`define GPC_ADDR_P1_OD 8'h92
`define GPC_ADDR_P2_OD 8'h93
`define GPC_ADDR_P1_CHG_EN 8'h94
`define GPC_ADDR_P0_DIR 8'hA1
`define GPC_ADDR_P0_PU 8'hAC
`define GPC_ADDR_P1_PU 8'hAD
`define GPC_ADDR_P2_PU 8'hAE
`define GPC_ADDR_P1_DIR 8'hB1
`define GPC_ADDR_P2_DIR 8'hB9
`define GPC_ADDR_P0_FSL 8'hD2
`define GPC_ADDR_P0_FSH 8'hD3
`define GPC_ADDR_P1_FSL 8'hD4
`define GPC_ADDR_P1_FSH 8'hD5
`define GPC_ADDR_P2_FS 8'hD6
`define GPC_ADDR_P0_DB 8'hDE
`define GPC_ADDR_P1_DB 8'hDF
`define GPC_ADDR_P0_IRQ_ST 8'hF1
`define GPC_ADDR_P0_IRQ_MASK 8'hF2
`define GPC_ADDR_P1_IRQ_ST 8'hF3

`define GPC_RST_VAL 8'h00
`define GPC_P2_WIDTH 3
`define GPC_P2_FS_WIDTH 4

// debounce register layout of port 0
`define GPC_DB_CLK_MSB 7
`define GPC_DB_CLK_LSB 6
`define GPC_DB_EN_MSB 5
`define GPC_DB_FIRST_PIN 2

// debounce sampling clock codes and divide counts
`define GPC_DEBOUNCE_CLOCK_SELECT_DIV1 2'h0
`define GPC_DEBOUNCE_CLOCK_SELECT_DIV4 2'h1
`define GPC_DEBOUNCE_CLOCK_SELECT_DIV4096 2'h2
`define GPC_DEBOUNCE_CLOCK_SELECT_LSOSC 2'h3
`define GPC_DIV4_LAST 2'h3
`define GPC_DIV4096_LAST 12'hFFF
`define GPC_DB_DIV_WIDTH 12

// function select codes and kinds
`define GPC_FS_IO 2'h0
`define GPC_FS_ALT_A 2'h1
`define GPC_FS_ALT_B 2'h2
`define GPC_FS_ANALOG 2'h3

`endif

// ==== verilog/gpc_db_tick.v ====
// debounce sampling tick generator for the port block
// assumes the low-speed oscillator level arrives synchronous to i_clk
`timescale 1ns/100ps
`include "gpc_port_regs.vh"

module gpc_db_tick (
    input wire i_clk,
    input wire i_rst_n,
    input wire [1:0] i_sel,
    input wire i_lsosc,
    output reg o_tick
);
    reg [`GPC_DB_DIV_WIDTH-1:0] div_r;
    reg lsosc_r;

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            div_r <= {`GPC_DB_DIV_WIDTH{1'b0}};
            lsosc_r <= 1'b0;
        end else begin
            div_r <= div_r + 1'b1;
            lsosc_r <= i_lsosc;
        end
    end

    always @* begin
        case (i_sel)
            `GPC_DEBOUNCE_CLOCK_SELECT_DIV1: o_tick = 1'b1;
            `GPC_DEBOUNCE_CLOCK_SELECT_DIV4: o_tick = (div_r[1:0] == `GPC_DIV4_LAST);
            `GPC_DEBOUNCE_CLOCK_SELECT_DIV4096: o_tick = (div_r == `GPC_DIV4096_LAST);
            `GPC_DEBOUNCE_CLOCK_SELECT_LSOSC: o_tick = i_lsosc & ~lsosc_r;
            default: o_tick = 1'b0;
        endcase
    end
endmodule // gpc_db_tick

// ==== verilog/gpc_db_pin.v ====
// one-pin debounce filter for the port block
// assumes i_tick is a one-cycle sampling strobe in the i_clk domain
`timescale 1ns/100ps
`include "gpc_port_regs.vh"

module gpc_db_pin (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_pin,
    input wire i_en,
    input wire i_tick,
    output reg o_level
);
    reg [1:0] hist_r;

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            hist_r <= 2'h0;
            o_level <= 1'b0;
        end else if (!i_en) begin
            // filter off: pass the pin through, keep history fresh
            hist_r <= {i_pin, i_pin};
            o_level <= i_pin;
        end else if (i_tick) begin
            hist_r <= {hist_r[0], i_pin};
            if (hist_r[1] == i_pin && hist_r[0] == i_pin)
                o_level <= i_pin;
        end
    end
endmodule // gpc_db_pin

// ==== verilog/gpc_port_ctrl.v ====
// general-purpose port block: three ports, debounce, port 0 function mux,
// pin change interrupts; assumes synchronous pin inputs and a one-cycle
// strobed register bus with read data in the following cycle
`timescale 1ns/100ps
`include "gpc_port_regs.vh"

module gpc_port_ctrl (
    input wire i_clk,
    input wire i_rst_n,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    output wire o_irq,
    input wire i_stop,
    input wire i_lsosc,
    input wire [7:0] i_p0_pin,
    output wire [7:0] o_p0_out,
    output wire [7:0] o_p0_oe,
    output wire [7:0] o_p0_pu,
    output wire [7:0] o_p0_analog,
    input wire [7:0] i_p0_alt_a_out,
    input wire [7:0] i_p0_alt_a_oe,
    input wire [7:0] i_p0_alt_b_out,
    input wire [7:0] i_p0_alt_b_oe,
    output wire [7:0] o_p0_alt_in,
    output wire o_ext_counter_clk,
    output wire o_ext_irq_in,
    input wire [7:0] i_p1_pin,
    output wire [7:0] o_p1_out,
    output wire [7:0] o_p1_oe,
    output wire [7:0] o_p1_pu,
    output wire [7:0] o_p1_fsel_low,
    output wire [7:0] o_p1_fsel_high,
    input wire [2:0] i_p2_pin,
    output wire [2:0] o_p2_out,
    output wire [2:0] o_p2_oe,
    output wire [2:0] o_p2_pu,
    output wire [3:0] o_p2_fsel
);
    // port 0 control registers
    reg [7:0] p0_data_r, p0_dir_r, p0_pu_r, p0_od_r, p0_db_r;
    reg [7:0] p0_fsl_r, p0_fsh_r;

    // port 1 control registers; the change enable doubles as its interrupt mask
    reg [7:0] p1_data_r, p1_dir_r, p1_pu_r, p1_od_r, p1_db_r;
    reg [7:0] p1_fsl_r, p1_fsh_r, p1_chg_en_r;

    // port 2 has three pins, so only the low bits are stored
    reg [2:0] p2_data_r, p2_dir_r, p2_pu_r, p2_od_r;
    reg [3:0] p2_fs_r;

    // interrupt status, mask and filtered levels of the last cycle
    reg [7:0] p0_irq_st_r, p0_irq_mask_r, p1_irq_st_r;
    reg [7:0] p0_deb_prev_r, p1_deb_prev_r;
    reg [7:0] rdata_nxt;
    reg [7:0] p0_out_nxt, p0_oe_nxt, p0_analog_nxt;

    wire db_tick;
    wire [7:0] p0_deb, p1_deb;
    wire [15:0] p0_fs_all;
    wire [7:0] p0_db_en;
    wire [7:0] p0_chg, p1_chg;

    // kind of function a port 0 code selects on a given pin
    function [1:0] fs_kind;
        input [2:0] pin;
        input [1:0] code;
        begin
            fs_kind = `GPC_FS_IO;
            case (code)
                `GPC_FS_ALT_A:
                    if (pin != 3'd3 && pin != 3'd4)
                        fs_kind = `GPC_FS_ALT_A;
                `GPC_FS_ALT_B:
                    if (pin == 3'd3 || pin == 3'd4 || pin == 3'd6 || pin == 3'd7)
                        fs_kind = `GPC_FS_ALT_B;
                `GPC_FS_ANALOG:
                    if (pin != 3'd2)
                        fs_kind = `GPC_FS_ANALOG;
                default: fs_kind = `GPC_FS_IO; // reserved codes stay plain I/O
            endcase
        end
    endfunction

    // pin drive for plain I/O: open-drain only ever pulls low
    function [1:0] io_drive;
        input d;
        input dir;
        input od;
        begin
            io_drive = {dir & ~(od & d), d & ~od};
        end
    endfunction

    // data register read: output bits return the latch, input bits the pin
    function [7:0] pin_rd;
        input [7:0] d;
        input [7:0] dir;
        input [7:0] pin;
        begin
            pin_rd = (d & dir) | (pin & ~dir);
        end
    endfunction

    // register write side
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            p0_data_r <= `GPC_RST_VAL;
            p0_dir_r <= `GPC_RST_VAL;
            p0_pu_r <= `GPC_RST_VAL;
            p0_od_r <= `GPC_RST_VAL;
            p0_db_r <= `GPC_RST_VAL;
            p0_fsl_r <= `GPC_RST_VAL;
            p0_fsh_r <= `GPC_RST_VAL;
            p1_data_r <= `GPC_RST_VAL;
            p1_dir_r <= `GPC_RST_VAL;
            p1_pu_r <= `GPC_RST_VAL;
            p1_od_r <= `GPC_RST_VAL;
            p1_db_r <= `GPC_RST_VAL;
            p1_fsl_r <= `GPC_RST_VAL;
            p1_fsh_r <= `GPC_RST_VAL;
            p1_chg_en_r <= `GPC_RST_VAL;
            p2_data_r <= 3'h0;
            p2_dir_r <= 3'h0;
            p2_pu_r <= 3'h0;
            p2_od_r <= 3'h0;
            p2_fs_r <= 4'h0;
            p0_irq_mask_r <= `GPC_RST_VAL;
        end else if (i_wr) begin
            case (i_addr)
                `GPC_ADDR_P0_DATA: p0_data_r <= i_wdata;
                `GPC_ADDR_P0_DIR: p0_dir_r <= i_wdata;
                `GPC_ADDR_P0_PU: p0_pu_r <= i_wdata;
                `GPC_ADDR_P0_OD: p0_od_r <= i_wdata;
                `GPC_ADDR_P0_DB: p0_db_r <= i_wdata;
                `GPC_ADDR_P0_FSL: p0_fsl_r <= i_wdata;
                `GPC_ADDR_P0_FSH: p0_fsh_r <= i_wdata;
                `GPC_ADDR_P1_DATA: p1_data_r <= i_wdata;
                `GPC_ADDR_P1_DIR: p1_dir_r <= i_wdata;
                `GPC_ADDR_P1_PU: p1_pu_r <= i_wdata;
                `GPC_ADDR_P1_OD: p1_od_r <= i_wdata;
                `GPC_ADDR_P1_DB: p1_db_r <= i_wdata;
                `GPC_ADDR_P1_FSL: p1_fsl_r <= i_wdata;
                `GPC_ADDR_P1_FSH: p1_fsh_r <= i_wdata;
                `GPC_ADDR_P1_CHG_EN: p1_chg_en_r <= i_wdata;
                `GPC_ADDR_P2_DATA: p2_data_r <= i_wdata[2:0];
                `GPC_ADDR_P2_DIR: p2_dir_r <= i_wdata[2:0];
                `GPC_ADDR_P2_PU: p2_pu_r <= i_wdata[2:0];
                `GPC_ADDR_P2_OD: p2_od_r <= i_wdata[2:0];
                `GPC_ADDR_P2_FS: p2_fs_r <= i_wdata[3:0];
                `GPC_ADDR_P0_IRQ_MASK: p0_irq_mask_r <= i_wdata;
                default: p0_irq_mask_r <= p0_irq_mask_r;
            endcase
        end
    end

    // read side: data registers return the pin on input bits
    always @* begin
        case (i_addr)
            `GPC_ADDR_P0_DATA: rdata_nxt = pin_rd(p0_data_r, p0_dir_r, i_p0_pin);
            `GPC_ADDR_P0_DIR: rdata_nxt = p0_dir_r;
            `GPC_ADDR_P0_PU: rdata_nxt = p0_pu_r;
            `GPC_ADDR_P0_OD: rdata_nxt = p0_od_r;
            `GPC_ADDR_P0_DB: rdata_nxt = p0_db_r;
            `GPC_ADDR_P0_FSL: rdata_nxt = p0_fsl_r;
            `GPC_ADDR_P0_FSH: rdata_nxt = p0_fsh_r;
            `GPC_ADDR_P1_DATA: rdata_nxt = pin_rd(p1_data_r, p1_dir_r, i_p1_pin);
            `GPC_ADDR_P1_DIR: rdata_nxt = p1_dir_r;
            `GPC_ADDR_P1_PU: rdata_nxt = p1_pu_r;
            `GPC_ADDR_P1_OD: rdata_nxt = p1_od_r;
            `GPC_ADDR_P1_DB: rdata_nxt = p1_db_r;
            `GPC_ADDR_P1_FSL: rdata_nxt = p1_fsl_r;
            `GPC_ADDR_P1_FSH: rdata_nxt = p1_fsh_r;
            `GPC_ADDR_P1_CHG_EN: rdata_nxt = p1_chg_en_r;
            `GPC_ADDR_P2_DATA:
                rdata_nxt = pin_rd({5'h00, p2_data_r}, {5'h00, p2_dir_r}, {5'h00, i_p2_pin});
            `GPC_ADDR_P2_DIR: rdata_nxt = {5'h00, p2_dir_r};
            `GPC_ADDR_P2_PU: rdata_nxt = {5'h00, p2_pu_r};
            `GPC_ADDR_P2_OD: rdata_nxt = {5'h00, p2_od_r};
            `GPC_ADDR_P2_FS: rdata_nxt = {4'h0, p2_fs_r};
            `GPC_ADDR_P0_IRQ_ST: rdata_nxt = p0_irq_st_r;
            `GPC_ADDR_P0_IRQ_MASK: rdata_nxt = p0_irq_mask_r;
            `GPC_ADDR_P1_IRQ_ST: rdata_nxt = p1_irq_st_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // answer stands one cycle; idle cycles read 00
    always @(posedge i_clk) begin
        if (!i_rst_n)
            o_rdata <= 8'h00;
        else if (i_rd)
            o_rdata <= rdata_nxt;
        else
            o_rdata <= 8'h00;
    end

    // debounce: one shared sampling clock, selected by port 0 top bits
    gpc_db_tick u_tick (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_sel(p0_db_r[`GPC_DB_CLK_MSB:`GPC_DB_CLK_LSB]),
        .i_lsosc(i_lsosc),
        .o_tick(db_tick)
    );

    // pins 0 and 1 of port 0 have no enable bit
    assign p0_db_en = {p0_db_r[`GPC_DB_EN_MSB:0], 2'b00};

    // stop mode bypasses the filters so wake-up edges are not held back
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_db
            gpc_db_pin u_p0 (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_pin(i_p0_pin[gi]),
                .i_en(p0_db_en[gi] & ~i_stop),
                .i_tick(db_tick),
                .o_level(p0_deb[gi])
            );
            gpc_db_pin u_p1 (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_pin(i_p1_pin[gi]),
                .i_en(p1_db_r[gi] & ~i_stop),
                .i_tick(db_tick),
                .o_level(p1_deb[gi])
            );
        end
    endgenerate

    // port 0 pin drive with alternate function override
    assign p0_fs_all = {p0_fsh_r, p0_fsl_r};

    integer k;
    reg [1:0] kind_v;
    reg [1:0] drv_v;
    always @* begin
        p0_out_nxt = 8'h00;
        p0_oe_nxt = 8'h00;
        p0_analog_nxt = 8'h00;
        kind_v = `GPC_FS_IO;
        drv_v = 2'b00;
        for (k = 0; k < 8; k = k + 1) begin
            kind_v = fs_kind(k[2:0], p0_fs_all[2*k +: 2]);
            drv_v = io_drive(p0_data_r[k], p0_dir_r[k], p0_od_r[k]);
            case (kind_v)
                `GPC_FS_ALT_A: begin
                    p0_out_nxt[k] = i_p0_alt_a_out[k];
                    p0_oe_nxt[k] = i_p0_alt_a_oe[k];
                end
                `GPC_FS_ALT_B: begin
                    p0_out_nxt[k] = i_p0_alt_b_out[k];
                    p0_oe_nxt[k] = i_p0_alt_b_oe[k];
                end
                `GPC_FS_ANALOG: p0_analog_nxt[k] = 1'b1; // driver off
                default: begin
                    p0_out_nxt[k] = drv_v[0];
                    p0_oe_nxt[k] = drv_v[1];
                end
            endcase
        end
    end

    assign o_p0_out = p0_out_nxt;
    assign o_p0_oe = p0_oe_nxt;
    assign o_p0_analog = p0_analog_nxt;
    // analog pins lose the pull-up so the channel sees the true level
    assign o_p0_pu = p0_pu_r & ~p0_analog_nxt;
    assign o_p0_alt_in = p0_deb;
    // gated off while the direction bit of pin 0 is set; an alternate function driving pin 0 is not gated
    assign o_ext_counter_clk = p0_deb[0] & ~p0_dir_r[0];
    assign o_ext_irq_in = p0_deb[2];

    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_p1
            wire [1:0] drv;
            assign drv = io_drive(p1_data_r[gi], p1_dir_r[gi], p1_od_r[gi]);
            assign o_p1_out[gi] = drv[0];
            assign o_p1_oe[gi] = drv[1];
        end
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_p2
            wire [1:0] drv;
            assign drv = io_drive(p2_data_r[gi], p2_dir_r[gi], p2_od_r[gi]);
            assign o_p2_out[gi] = drv[0];
            assign o_p2_oe[gi] = drv[1];
        end
    endgenerate

    assign o_p1_pu = p1_pu_r;
    assign o_p2_pu = p2_pu_r;
    assign o_p1_fsel_low = p1_fsl_r;
    assign o_p1_fsel_high = p1_fsh_r;
    assign o_p2_fsel = p2_fs_r;

    // pin change events on the filtered levels
    assign p0_chg = p0_deb ^ p0_deb_prev_r;
    assign p1_chg = p1_deb ^ p1_deb_prev_r;

    wire rd_p0_st = i_rd && (i_addr == `GPC_ADDR_P0_IRQ_ST);
    wire rd_p1_st = i_rd && (i_addr == `GPC_ADDR_P1_IRQ_ST);
    wire [7:0] p0_st_keep = rd_p0_st ? 8'h00 : p0_irq_st_r;
    wire [7:0] p1_st_keep = rd_p1_st ? 8'h00 : p1_irq_st_r;

    // a change in the same cycle as the clearing read survives
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            p0_deb_prev_r <= 8'h00;
            p1_deb_prev_r <= 8'h00;
            p0_irq_st_r <= 8'h00;
            p1_irq_st_r <= 8'h00;
        end else begin
            p0_deb_prev_r <= p0_deb;
            p1_deb_prev_r <= p1_deb;
            p0_irq_st_r <= p0_st_keep | p0_chg;
            p1_irq_st_r <= p1_st_keep | p1_chg;
        end
    end

    wire p0_irq_any = |(p0_irq_st_r & p0_irq_mask_r);
    wire p1_irq_any = |(p1_irq_st_r & p1_chg_en_r);
    assign o_irq = p0_irq_any | p1_irq_any;
endmodule // gpc_port_ctrl

// ==== verification/gpc_port_ctrl_assertions.sv ====
// checker of the port block: bus idle data, pin control and debounce
// assumes it is bound to gpc_port_ctrl and sees only its ports
`timescale 1ns/100ps

module gpc_port_ctrl_assertions (
    input wire i_clk,
    input wire i_rst_n,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    input wire i_stop,
    input wire [7:0] i_p0_pin,
    input wire [7:0] o_p0_oe,
    input wire [7:0] o_p0_pu,
    input wire [7:0] o_p0_analog,
    input wire o_ext_counter_clk,
    input wire o_ext_irq_in,
    input wire [7:0] o_p1_pu,
    input wire [7:0] o_p1_fsel_low,
    input wire [2:0] o_p2_oe,
    input wire [3:0] o_p2_fsel
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    chk_rdata_idle: assert property (
        !$past(i_rd) |-> o_rdata == 8'h00) else $error("read data not idle");
    chk_p0_pullup: assert property (
        i_wr && i_addr == 8'hAC |=> o_p0_pu == ($past(i_wdata) & ~o_p0_analog))
        else $error("port 0 pull-up mismatch");
    chk_p1_pullup: assert property (
        i_wr && i_addr == 8'hAD |=> o_p1_pu == $past(i_wdata))
        else $error("port 1 pull-up mismatch");
    chk_p2_dir_in: assert property (
        i_wr && i_addr == 8'hB9 && i_wdata[2:0] == 3'h0 |=> o_p2_oe == 3'h0)
        else $error("port 2 input pin driven");
    chk_counter_clk_dir: assert property (
        i_wr && i_addr == 8'hA1 && i_wdata[0] |=> !o_ext_counter_clk)
        else $error("counter clock passes on output pin");
    chk_p1_fsel_store: assert property (
        i_wr && i_addr == 8'hD4 |=> o_p1_fsel_low == $past(i_wdata))
        else $error("port 1 select not stored");
    chk_p2_fsel_store: assert property (
        i_wr && i_addr == 8'hD6 |=> o_p2_fsel == $past(i_wdata[3:0]))
        else $error("port 2 select not stored");
    chk_analog_release: assert property (
        o_p0_analog != 8'h00 |-> (o_p0_analog & (o_p0_oe | o_p0_pu)) == 8'h00)
        else $error("analog pin still driven");
    chk_stop_bypass: assert property (
        i_stop && $past(i_stop) && $past(i_rst_n) |-> o_ext_irq_in == $past(i_p0_pin[2]))
        else $error("debounce active in stop");
    chk_filter_agree: assert property (
        $changed(o_ext_irq_in) && $past(i_rst_n) |-> o_ext_irq_in == $past(i_p0_pin[2]))
        else $error("filtered level against pin");
endmodule // gpc_port_ctrl_assertions

bind gpc_port_ctrl gpc_port_ctrl_assertions u_chk (.i_clk, .i_rst_n, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_stop, .i_p0_pin, .o_p0_oe, .o_p0_pu, .o_p0_analog,
    .o_ext_counter_clk, .o_ext_irq_in, .o_p1_pu, .o_p1_fsel_low, .o_p2_oe, .o_p2_fsel);

// ==== verification/gpc_pin_model.sv ====
// port 0 pad model: block driver, outside source, pull-up, floating
// assumes the outside source is enabled by the bench per pin
`timescale 1ns/100ps

module gpc_pin_model (
    input wire i_clk,
    input wire [7:0] i_out,
    input wire [7:0] i_oe,
    input wire [7:0] i_pu,
    input wire [7:0] i_ext,
    input wire [7:0] i_ext_en,
    output logic [7:0] o_pin
);
    logic [7:0] float_r = 8'h55;

    // a floating pad must never look settled
    always @(posedge i_clk) begin
        float_r <= ~float_r;
    end
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            if (i_oe[k]) begin
                o_pin[k] = i_out[k];
            end else if (i_ext_en[k]) begin
                o_pin[k] = i_ext[k];
            end else if (i_pu[k]) begin
                o_pin[k] = 1'b1;
            end else begin
                o_pin[k] = float_r[k];
            end
        end
    end
endmodule // gpc_pin_model

// ==== verification/testbench.sv ====
// bench of the port block driven through its register bus
// assumes the pad model on port 0; port 1 pins driven directly
`timescale 1ns/100ps

module testbench;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_stop = 1'b0;
    logic i_lsosc = 1'b0;
    logic [7:0] p1_pin = 8'h00;
    logic [2:0] p2_pin = 3'h0;
    logic [7:0] ext = 8'h00;
    logic [7:0] p0_pin, rdata, p0_out, p0_oe, p0_pu, p0_an, p1_oe, d;
    logic [2:0] p2_out;
    logic irq, ext_irq;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    int tick_len [4] = '{1, 4, 4096, 16};
    logic [7:0] oe_exp [4] = '{8'h00, 8'hE7, 8'hD8, 8'h00};
    logic [7:0] out_exp [4] = '{8'h00, 8'hE7, 8'h00, 8'h00};
    logic [7:0] an_exp [4] = '{8'h00, 8'h00, 8'h00, 8'hFB};
    // address in the high byte, readable bits in the low byte
    logic [15:0] tbl [22] = '{16'h8000, 16'h8800, 16'h9000, 16'h91FF, 16'h92FF, 16'h9307,
        16'h94FF, 16'hA1FF, 16'hACFF, 16'hADFF, 16'hAE07, 16'hB1FF, 16'hB907, 16'hD2FF,
        16'hD3FF, 16'hD4FF, 16'hD5FF, 16'hD60F, 16'hDEFF, 16'hDFFF, 16'hF2FF, 16'h8100};

    gpc_port_ctrl DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .o_irq(irq),
        .i_stop(i_stop), .i_lsosc(i_lsosc), .i_p0_pin(p0_pin), .o_p0_out(p0_out),
        .o_p0_oe(p0_oe), .o_p0_pu(p0_pu), .o_p0_analog(p0_an), .i_p0_alt_a_out(8'hFF),
        .i_p0_alt_a_oe(8'hFF), .i_p0_alt_b_out(8'h00), .i_p0_alt_b_oe(8'hFF),
        .o_p0_alt_in(), .o_ext_counter_clk(), .o_ext_irq_in(ext_irq), .i_p1_pin(p1_pin),
        .o_p1_out(), .o_p1_oe(p1_oe), .o_p1_pu(), .o_p1_fsel_low(), .o_p1_fsel_high(),
        .i_p2_pin(p2_pin), .o_p2_out(p2_out), .o_p2_oe(), .o_p2_pu(), .o_p2_fsel());
    gpc_pin_model u_pads (.i_clk(i_clk), .i_out(p0_out), .i_oe(p0_oe), .i_pu(p0_pu),
        .i_ext(ext), .i_ext_en(8'hFF), .o_pin(p0_pin));

    always #10 i_clk = ~i_clk;
    // slowest debounce mode needs some 57000 cycles
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        i_lsosc <= cyc[3];
        if (cyc == 65000) begin
            errors++;
            results();
        end
    end

    task automatic results();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    // pin 2 level held for exactly n i_clk cycles
    task automatic hold(input logic v, input int n);
        ext[2] <= v;
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    initial begin
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        foreach (tbl[i]) begin
            rchk(tbl[i][15:8], 8'h00);
            wr(tbl[i][15:8], 8'hA5);
            rchk(tbl[i][15:8], 8'hA5 & tbl[i][7:0]);
            wr(tbl[i][15:8], 8'h00);
        end
        $display("test registers done");
        wr(8'hA1, 8'hFF);
        wr(8'h80, 8'h5A);
        chk(p0_out, 8'h5A);
        chk(p0_oe, 8'hFF);
        rchk(8'h80, 8'h5A);
        wr(8'h91, 8'hFF);
        wr(8'h80, 8'h0F);
        chk(p0_oe, 8'hF0);
        chk(p0_out, 8'h00);
        wr(8'h91, 8'h00);
        wr(8'hA1, 8'h00);
        wr(8'h80, 8'h00);
        ext <= 8'h3C;
        rchk(8'h80, 8'h3C);
        wr(8'hB1, 8'h0F);
        wr(8'h88, 8'hA5);
        p1_pin <= 8'h3C;
        rchk(8'h88, 8'h35);
        chk(p1_oe, 8'h0F);
        rchk(8'hF3, 8'h3C);
        wr(8'hB9, 8'h07);
        wr(8'h90, 8'h05);
        chk({5'h00, p2_out}, 8'h05);
        wr(8'hB9, 8'h00);
        p2_pin <= 3'h6;
        rchk(8'h90, 8'h06);
        $display("test pins done");
        for (int c = 0; c < 4; c++) begin
            wr(8'hD2, {4{c[1:0]}});
            wr(8'hD3, {4{c[1:0]}});
            chk(p0_oe, oe_exp[c]);
            chk(p0_out, out_exp[c]);
            chk(p0_an, an_exp[c]);
        end
        wr(8'hD2, 8'h00);
        wr(8'hD3, 8'h00);
        $display("test functions done");
        ext <= 8'h00;
        for (int m = 0; m < 4; m++) begin
            wr(8'hDE, {m[1:0], 6'h01});
            hold(1'b1, 2 * tick_len[m]);
            hold(1'b0, 4 * tick_len[m]);
            chk({7'h00, ext_irq}, 8'h00);
            hold(1'b1, 4 * tick_len[m]);
            chk({7'h00, ext_irq}, 8'h01);
            hold(1'b0, 4 * tick_len[m]);
            chk({7'h00, ext_irq}, 8'h00);
        end
        wr(8'hDE, 8'h41);
        i_stop <= 1'b1;
        hold(1'b1, 2);
        chk({7'h00, ext_irq}, 8'h01);
        hold(1'b0, 2);
        i_stop <= 1'b0;
        hold(1'b1, 4);
        chk({7'h00, ext_irq}, 8'h00);
        hold(1'b0, 16);
        $display("test debounce done");
        wr(8'hDE, 8'h01);
        // every port 0 pin has moved in the earlier tests and nothing read the status
        rchk(8'hF1, 8'hFF);
        rchk(8'hF1, 8'h00);
        hold(1'b1, 5);
        chk({7'h00, irq}, 8'h00);
        rchk(8'hF1, 8'h04);
        wr(8'hF2, 8'h04);
        hold(1'b0, 5);
        chk({7'h00, irq}, 8'h01);
        rchk(8'hF1, 8'h04);
        hold(1'b0, 1);
        chk({7'h00, irq}, 8'h00);
        $display("test interrupt done");
        results();
    end
endmodule // testbench
